// ==== test_vga_gain_ctrl.sv ====
// Self-checking bench for the gain control front end
`timescale 1ns/1ns
`default_nettype none
module test_vga_gain_ctrl;
  logic        clk;
  logic        rst;
  logic        sel_msb;
  logic        sel_lsb;
  logic        perf;
  logic        power;
  logic        hold;
  logic [5:0]  pins;
  logic        sdo;
  logic        sdo_oe_n;
  logic [5:0]  gain;
  logic [1:0]  mode;
  logic        perf_q;
  logic        power_q;
  logic [15:0] rd;
  int          errors;
  int          num_checks;
  int          e;
  // System clock, 4 ns period
  initial clk = 1'b0;
  always #2 clk = ~clk;
  vga_gain_ctrl u_vga_gain_ctrl (.CLK_IN(clk), .RST_IN(rst), .SERIAL_CLK_IN(pins[4]),
    .IFACE_SEL_MSB_IN(sel_msb), .IFACE_SEL_LSB_IN(sel_lsb), .PERF_SELECT_IN(perf), .POWER_UP_IN(power),
    .LATCH_HOLD_IN(hold), .SHARED_PIN_IN(pins), .SERIAL_DATA_OUT(sdo), .SERIAL_DATA_OE_N_OUT(sdo_oe_n),
    .GAIN_CODE_OUT(gain), .IFACE_MODE_OUT(mode), .PERF_SELECT_OUT(perf_q), .POWER_UP_OUT(power_q));
  vga_gain_host u_vga_gain_host (.clk_in(clk), .data_in(sdo), .data_oe_n_in(sdo_oe_n), .pins_out(pins));
  // Compare and count
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One step clock cycle, direction at rise and at fall
  task automatic step(input logic dr, input logic df, input logic [1:0] gs);
    u_vga_gain_host.set_pins({2'b00, gs, 1'b1, dr});
    wait_clk(4);
    u_vga_gain_host.set_pins({2'b00, gs, 1'b0, df});
    wait_clk(6);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #100000;
    errors++;
    final_report();
  end
  initial begin
    errors = 0;
    num_checks = 0;
    {rst, sel_msb, sel_lsb, perf, power, hold} <= 6'b100000;
    wait_clk(6);
    chk("gain in reset", 16'h003F, {10'h000, gain});
    rst <= 1'b0;
    u_vga_gain_host.set_pins(6'h2A);
    wait_clk(8);
    chk("parallel follow", 16'h002A, {10'h000, gain});
    hold <= 1'b1;
    wait_clk(8);
    u_vga_gain_host.set_pins(6'h08);
    wait_clk(8);
    chk("parallel hold", 16'h002A, {10'h000, gain});
    for (int i = 0; i < 4; i++) begin
      {sel_msb, sel_lsb} <= i[1:0];
      perf <= i[0];
      power <= i[1];
      wait_clk(8);
      chk("mode", (i < 2) ? i[15:0] : 16'h0002, {14'h0000, mode});
      chk("common pins", {14'h0000, i[0], i[1]}, {14'h0000, perf_q, power_q});
    end
    $display("test parallel and modes done");
    {sel_msb, sel_lsb} <= 2'b01;
    wait_clk(8);
    u_vga_gain_host.frame(16'h0025, rd);
    wait_clk(8);
    chk("serial write", 16'h0025, {10'h000, gain});
    u_vga_gain_host.frame(16'h8000, rd);
    u_vga_gain_host.frame(16'h0000, rd);
    chk("read back", 16'h0025, rd);
    wait_clk(8);
    chk("gain after read", 16'h0025, {10'h000, gain});
    u_vga_gain_host.frame(16'h7FC3, rd);
    wait_clk(8);
    chk("write after read", 16'h0003, {10'h000, gain});
    // every fast attack step from code 32
    for (int f = 0; f < 4; f++) begin
      e = (32 + (4 << f) > 63) ? 63 : 32 + (4 << f);
      u_vga_gain_host.frame({8'h00, f[1:0], 6'h20}, rd);
      wait_clk(8);
      u_vga_gain_host.set_pins(6'h0C);
      wait_clk(8);
      chk("fast attack", e[15:0], {10'h000, gain});
      u_vga_gain_host.set_pins(6'h08);
      wait_clk(4);
    end
    $display("test serial done");
    u_vga_gain_host.set_pins(6'h00);
    {sel_msb, sel_lsb} <= 2'b10;
    wait_clk(8);
    step(1'b1, 1'b0, 2'b00);
    chk("updown reset", 16'h003F, {10'h000, gain});
    e = 63;
    for (int s = 0; s < 4; s++) begin
      step(1'b1, 1'b1, s[1:0]);
      e = e - (1 << s);
      chk("step up", e[15:0], {10'h000, gain});
    end
    step(1'b0, 1'b0, 2'b11);
    chk("step down", 16'h0038, {10'h000, gain});
    step(1'b0, 1'b0, 2'b11);
    chk("clamp bottom", 16'h003F, {10'h000, gain});
    repeat (8) step(1'b1, 1'b1, 2'b11);
    chk("clamp top", 16'h0000, {10'h000, gain});
    // Reset gesture of the other polarity, from code 0
    step(1'b0, 1'b1, 2'b00);
    chk("updown reset from top", 16'h003F, {10'h000, gain});
    $display("test up/down done");
    final_report();
  end
endmodule // test_vga_gain_ctrl
`default_nettype wire

// ==== vga_gain_ctrl.sv ====
// Gain control front end: interface select, parallel hold, serial port with fast attack, up/down stepping
`timescale 1ns/1ns
`default_nettype none
`include "vga_gain_params.svh"
module vga_gain_ctrl (
  // System clock and reset
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  // Serial clock, same wire as shared pin 4
  input  wire logic       SERIAL_CLK_IN,
  // Interface select and common pins
  input  wire logic       IFACE_SEL_MSB_IN,
  input  wire logic       IFACE_SEL_LSB_IN,
  input  wire logic       PERF_SELECT_IN,
  input  wire logic       POWER_UP_IN,
  input  wire logic       LATCH_HOLD_IN,
  // Shared gain control pins
  input  wire logic [5:0] SHARED_PIN_IN,
  // Serial data line drive
  output var  logic       SERIAL_DATA_OUT,
  output var  logic       SERIAL_DATA_OE_N_OUT,
  // Applied state
  output var  logic [5:0] GAIN_CODE_OUT,
  output var  logic [1:0] IFACE_MODE_OUT,
  output var  logic       PERF_SELECT_OUT,
  output var  logic       POWER_UP_OUT
);

  // ---------------------------------------------------------------
  // Serial link domain
  // ---------------------------------------------------------------

  vga_gain_pkg::link_frame_t frame;
  vga_gain_pkg::link_frame_t next_frame;
  vga_gain_pkg::link_hold_t  hold;
  vga_gain_pkg::link_hold_t  next_hold;

  logic        serial_select_n;
  logic        serial_din;
  logic        frame_is_read;
  logic        frame_last_edge;
  logic [15:0] frame_word;
  logic [3:0]  read_index;

  // shared pin roles
  // In serial mode pin 5 is data and pin 3 the low select
  assign serial_select_n = SHARED_PIN_IN[3];
  assign serial_din      = SHARED_PIN_IN[5];

  // First edge takes the pending flag, later edges the frame copy
  assign frame_is_read   = (frame.cnt == 5'h00) ? hold.read_pending : frame.reading;
  assign frame_last_edge = (frame.cnt == `FRAME_LAST);
  assign frame_word      = {frame.shift, serial_din};
  assign read_index      = 4'hF - frame.cnt[3:0];

  // Frame state: shift in, count edges, drive read data
  always_comb begin
    next_frame = frame;
    // exactly sixteen clocks
    // Edges past the sixteenth leave the frame untouched
    if (frame.cnt < `FRAME_BITS) begin
      next_frame.cnt   = frame.cnt + 5'h01;
      next_frame.shift = frame_word[14:0];
      if (frame.cnt == 5'h00) begin
        next_frame.reading = hold.read_pending;
      end
      // drive read data
      // One bit per rising edge, most significant first
      if (frame_is_read) begin
        next_frame.dout = hold.word[read_index];
        next_frame.oe_n = 1'b0;
      end
    end
  end

  // select gates the data line
  // Select high clears the frame and releases the line
  always_ff @(posedge SERIAL_CLK_IN or posedge serial_select_n) begin
    if (serial_select_n) begin
      frame <= '0;
      frame.oe_n <= 1'b1;
    end else begin
      frame <= next_frame;
    end
  end

  // Held word and read request, updated at the sixteenth edge
  always_comb begin
    next_hold = hold;
    if (frame_last_edge) begin
      if (frame.reading) begin
        next_hold.read_pending = 1'b0;
      end else if (frame_word[`WORD_RW_BIT]) begin
        // read request
        // Other bits of a read request are ignored
        next_hold.read_pending = 1'b1;
      end else begin
        next_hold.word                = frame_word;
        next_hold.word[`WORD_RW_BIT]  = 1'b0;
        next_hold.commit_tgl          = ~hold.commit_tgl;
      end
    end
  end

  // Held state survives between frames, cleared by system reset
  always_ff @(posedge SERIAL_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      hold <= '0;
      hold.word <= `WORD_RESET;
    end else begin
      hold <= next_hold;
    end
  end

  // two-way data line
  // Enable is low only while a read frame drives the line
  assign SERIAL_DATA_OUT      = frame.dout;
  assign SERIAL_DATA_OE_N_OUT = frame.oe_n;

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------

  logic [`SYNC_W-1:0] sync_raw;
  logic [`SYNC_W-1:0] sync_lvl;

  // Pins and the commit toggle pass two flip-flops first
  assign sync_raw = {hold.commit_tgl,
                     POWER_UP_IN,
                     PERF_SELECT_IN,
                     LATCH_HOLD_IN,
                     IFACE_SEL_MSB_IN,
                     IFACE_SEL_LSB_IN,
                     SHARED_PIN_IN};

  vga_sync_bank #(
    .WIDTH(`SYNC_W)
  ) u_sync (
    .clk_in  (CLK_IN),
    .rst_in  (RST_IN),
    .async_in(sync_raw),
    .sync_out(sync_lvl)
  );

  logic [5:0] parallel_gain_bits;
  logic       iface_sel_lsb;
  logic       iface_sel_msb;
  logic       latch_hold;
  logic       perf_select;
  logic       power_up;
  logic       commit_lvl;
  logic       step_direction;
  logic       step_clock;
  logic       step_size_lsb;
  logic       step_size_msb;
  logic       fast_attack_strobe;

  // pin roles by interface
  // Pins 3..0 carry step size, clock and direction in up/down mode
  assign parallel_gain_bits = sync_lvl[5:0];
  assign step_direction     = sync_lvl[0];
  assign step_clock         = sync_lvl[1];
  assign step_size_lsb      = sync_lvl[2];
  assign fast_attack_strobe = sync_lvl[2];
  assign step_size_msb      = sync_lvl[3];
  assign iface_sel_lsb      = sync_lvl[6];
  assign iface_sel_msb      = sync_lvl[7];
  assign latch_hold         = sync_lvl[8];
  assign perf_select        = sync_lvl[9];
  assign power_up           = sync_lvl[10];
  assign commit_lvl         = sync_lvl[11];

  vga_gain_pkg::core_t core;
  vga_gain_pkg::core_t next_core;

  function automatic logic [5:0] code_add(input logic [5:0] code, input logic [6:0] inc);
    logic [6:0] sum;
    sum = {1'b0, code} + inc;
    if (sum > {1'b0, `GAIN_MAX}) begin
      code_add = `GAIN_MAX;
    end else begin
      code_add = sum[5:0];
    end
  endfunction

  function automatic logic [5:0] code_sub(input logic [5:0] code, input logic [6:0] dec);
    logic [6:0] diff;
    diff = {1'b0, code} - dec;
    if (dec > {1'b0, code}) begin
      code_sub = `GAIN_MIN;
    end else begin
      code_sub = diff[5:0];
    end
  endfunction

  logic [6:0] fast_step;
  logic [6:0] updn_step;
  logic [1:0] fast_sel;
  logic [1:0] hold_word_fast;
  logic [5:0] hold_word_gain;

  // Held word is stable for sixteen serial clocks after each toggle
  assign hold_word_fast = hold.word[`WORD_FAST_MSB:`WORD_FAST_LSB];
  assign hold_word_gain = hold.word[`WORD_GAIN_MSB:`WORD_GAIN_LSB];
  assign fast_sel       = hold_word_fast;

  always_comb begin
    unique case (fast_sel)
      2'h0: fast_step = `FAST_STEP_0;
      2'h1: fast_step = `FAST_STEP_1;
      2'h2: fast_step = `FAST_STEP_2;
      2'h3: fast_step = `FAST_STEP_3;
    endcase
  end

  always_comb begin
    unique case ({step_size_msb, step_size_lsb})
      2'h0: updn_step = `UPDN_STEP_0;
      2'h1: updn_step = `UPDN_STEP_1;
      2'h2: updn_step = `UPDN_STEP_2;
      2'h3: updn_step = `UPDN_STEP_3;
    endcase
  end

  logic [5:0] serial_gain;

  // Gain after a serial commit, before any fast attack
  always_comb begin
    serial_gain = core.gain;
    if (commit_lvl != core.commit_d) begin
      serial_gain = hold_word_gain;
    end
  end

  // Next system state
  always_comb begin
    next_core              = core;
    next_core.step_clock_d = step_clock;
    next_core.strobe_d     = fast_attack_strobe;
    next_core.commit_d     = commit_lvl;
    next_core.perf         = perf_select;
    next_core.power        = power_up;

    if (iface_sel_msb) begin
      next_core.mode = vga_gain_pkg::MODE_UPDOWN;
    end else if (iface_sel_lsb) begin
      next_core.mode = vga_gain_pkg::MODE_SERIAL;
    end else begin
      next_core.mode = vga_gain_pkg::MODE_PARALLEL;
    end

    unique case (core.mode)
      vga_gain_pkg::MODE_PARALLEL: begin
        if (!latch_hold) begin
          next_core.gain = parallel_gain_bits;
        end
      end
      vga_gain_pkg::MODE_SERIAL: begin
        next_core.gain = serial_gain;
        // strobe applies attenuation
        // Once per rising strobe edge, so a long high does not repeat
        if (fast_attack_strobe && !core.strobe_d) begin
          next_core.gain = code_add(serial_gain, fast_step);
        end
      end
      vga_gain_pkg::MODE_UPDOWN: begin
        // Rising step clock captures the direction
        if (step_clock && !core.step_clock_d) begin
          next_core.rise_dir = step_direction;
        end
        // Falling step clock completes the step
        if (!step_clock && core.step_clock_d) begin
          if (step_direction != core.rise_dir) begin
            next_core.gain = `GAIN_MAX;
          end else if (step_direction) begin
            next_core.gain = code_sub(core.gain, updn_step);
          end else begin
            next_core.gain = code_add(core.gain, updn_step);
          end
        end
      end
      default: begin
        next_core.gain = core.gain;
      end
    endcase
  end

  // Register system state
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      core <= '{mode:         vga_gain_pkg::MODE_PARALLEL,
                gain:         `GAIN_RESET,
                step_clock_d: 1'b0,
                rise_dir:     1'b0,
                strobe_d:     1'b0,
                commit_d:     1'b0,
                perf:         1'b0,
                power:        1'b0};
    end else begin
      core <= next_core;
    end
  end

  // Outputs straight from system flops
  assign GAIN_CODE_OUT   = core.gain;
  assign IFACE_MODE_OUT  = core.mode;
  assign PERF_SELECT_OUT = core.perf;
  assign POWER_UP_OUT    = core.power;

endmodule // vga_gain_ctrl
`default_nettype wire

// ==== vga_gain_host.sv ====
// Host model driving the shared gain control pins and serial frames
`timescale 1ns/1ns
`default_nettype none
module vga_gain_host (
  // System clock for pin updates
  input  wire logic       clk_in,
  // Device drive of the data line
  input  wire logic       data_in,
  input  wire logic       data_oe_n_in,
  // Shared pins as seen on the wires
  output var  logic [5:0] pins_out
);
  logic [5:0] drv;
  // Data wire level: device wins while its enable is low
  always_comb begin
    pins_out    = drv;
    pins_out[5] = data_oe_n_in ? drv[5] : data_in;
  end
  // Select high at rest, so the frame state starts cleared
  initial drv <= 6'h08;
  // Whole pin set changed at a system clock edge
  task automatic set_pins(input logic [5:0] v);
    @(posedge clk_in);
    drv <= v;
  endtask
  task automatic frame(input logic [15:0] w, output logic [15:0] rd);
    drv[4:3] <= 2'b01;
    #101 drv[3] = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      drv[5] = w[i];
      #80 drv[4] = 1'b1;
      #80 rd[i] = pins_out[5];
      drv[4] = 1'b0;
    end
    // invert the data bit, then select high between frames
    #80 drv[5] = ~drv[5];
    drv[3] = 1'b1;
    #120;
  endtask
endmodule // vga_gain_host
`default_nettype wire

// ==== vga_gain_monitor.sv ====
// Concurrent checks on the gain control front end ports
`timescale 1ns/1ns
`default_nettype none
module vga_gain_monitor (
  // Clock and reset
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  // Watched inputs
  input wire logic       IFACE_SEL_MSB_IN,
  input wire logic       IFACE_SEL_LSB_IN,
  input wire logic       PERF_SELECT_IN,
  input wire logic       POWER_UP_IN,
  input wire logic       LATCH_HOLD_IN,
  input wire logic [5:0] SHARED_PIN_IN,
  // Watched outputs
  input wire logic       SERIAL_DATA_OE_N_OUT,
  input wire logic [5:0] GAIN_CODE_OUT,
  input wire logic [1:0] IFACE_MODE_OUT,
  input wire logic       PERF_SELECT_OUT,
  input wire logic       POWER_UP_OUT
);
  logic step_prev;
  logic rise_dir;
  // Direction captured at each step clock rise
  always_ff @(posedge CLK_IN) begin
    step_prev <= SHARED_PIN_IN[1];
    if (SHARED_PIN_IN[1] && !step_prev) rise_dir <= SHARED_PIN_IN[0];
  end
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  sequence sel_steady;
    $stable({IFACE_SEL_MSB_IN, IFACE_SEL_LSB_IN}) [*6];
  endsequence
  sequence par_follow;
    (IFACE_MODE_OUT == 2'h0 && !LATCH_HOLD_IN && $stable(SHARED_PIN_IN)) [*6];
  endsequence
  sequence par_hold;
    (IFACE_MODE_OUT == 2'h0 && LATCH_HOLD_IN) [*6];
  endsequence
  sequence step_quiet;
    (IFACE_MODE_OUT == 2'h2 && $stable(SHARED_PIN_IN[1])) [*6];
  endsequence
  sequence odd_fall;
    $fell(SHARED_PIN_IN[1]) && IFACE_MODE_OUT == 2'h2 && SHARED_PIN_IN[0] != rise_dir;
  endsequence
  reset_state_a: assert property ($fell(RST_IN) |-> GAIN_CODE_OUT == 6'h3F && IFACE_MODE_OUT == 2'h0)
    else $error("gain or mode wrong at reset release");
  mode_select_a: assert property (sel_steady |-> IFACE_MODE_OUT == (IFACE_SEL_MSB_IN ? 2'h2 : {1'b0, IFACE_SEL_LSB_IN}))
    else $error("interface mode does not match select pins");
  common_pins_a: assert property ($stable({PERF_SELECT_IN, POWER_UP_IN}) [*6] |->
    {PERF_SELECT_OUT, POWER_UP_OUT} == {PERF_SELECT_IN, POWER_UP_IN})
    else $error("common pins not passed through");
  data_idle_a: assert property (SHARED_PIN_IN[3] [*2] |-> SERIAL_DATA_OE_N_OUT)
    else $error("data line driven while select high");
  latch_follow_a: assert property (par_follow |-> GAIN_CODE_OUT == SHARED_PIN_IN)
    else $error("transparent latch does not follow pins");
  latch_hold_a: assert property (par_hold |-> $stable(GAIN_CODE_OUT))
    else $error("held latch changed gain");
  step_quiet_a: assert property (step_quiet |-> $stable(GAIN_CODE_OUT))
    else $error("gain moved without a step clock");
  updown_reset_a: assert property (odd_fall |-> ##[2:5] GAIN_CODE_OUT == 6'h3F)
    else $error("up/down reset did not force all ones");
endmodule // vga_gain_monitor
bind vga_gain_ctrl vga_gain_monitor u_vga_gain_monitor (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .IFACE_SEL_MSB_IN(IFACE_SEL_MSB_IN), .IFACE_SEL_LSB_IN(IFACE_SEL_LSB_IN), .PERF_SELECT_IN(PERF_SELECT_IN),
  .POWER_UP_IN(POWER_UP_IN), .LATCH_HOLD_IN(LATCH_HOLD_IN), .SHARED_PIN_IN(SHARED_PIN_IN),
  .SERIAL_DATA_OE_N_OUT(SERIAL_DATA_OE_N_OUT), .GAIN_CODE_OUT(GAIN_CODE_OUT), .IFACE_MODE_OUT(IFACE_MODE_OUT),
  .PERF_SELECT_OUT(PERF_SELECT_OUT), .POWER_UP_OUT(POWER_UP_OUT));
`default_nettype wire

// ==== vga_gain_params.svh ====
// Constants for the gain control front end: widths, field positions, reset values, steps
`ifndef VGA_GAIN_PARAMS_SVH
`define VGA_GAIN_PARAMS_SVH

// Gain code
`define GAIN_W          6
`define GAIN_MAX        6'h3F
`define GAIN_MIN        6'h00
`define GAIN_RESET      6'h3F

// Serial gain word layout
`define WORD_W          16
`define WORD_RESET      16'h0000
`define WORD_RW_BIT     15
`define WORD_FAST_MSB   7
`define WORD_FAST_LSB   6
`define WORD_GAIN_MSB   5
`define WORD_GAIN_LSB   0
`define FRAME_BITS      5'h10
`define FRAME_LAST      5'h0F

// Fast attack steps in code units (2, 4, 8, 16 dB at 0.5 dB per code)
`define FAST_STEP_0     7'h04
`define FAST_STEP_1     7'h08
`define FAST_STEP_2     7'h10
`define FAST_STEP_3     7'h20

// Up/down steps in code units (0.5, 1, 2, 4 dB)
`define UPDN_STEP_0     7'h01
`define UPDN_STEP_1     7'h02
`define UPDN_STEP_2     7'h04
`define UPDN_STEP_3     7'h08

// Synchroniser bank width
`define SYNC_W          12

`endif

// ==== vga_gain_pkg.sv ====
// Types for the gain control front end
`default_nettype none
package vga_gain_pkg;

  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_SERIAL,
    MODE_UPDOWN
  } iface_mode_t;

  // Serial frame state, cleared whenever the select line is high
  typedef struct packed {
    logic [4:0]  cnt;
    logic [14:0] shift;
    logic        reading;
    logic        dout;
    logic        oe_n;
  } link_frame_t;

  // Serial state that outlives a frame
  typedef struct packed {
    logic [15:0] word;
    logic        read_pending;
    logic        commit_tgl;
  } link_hold_t;

  // System clock state
  typedef struct packed {
    iface_mode_t mode;
    logic [5:0]  gain;
    logic        step_clock_d;
    logic        rise_dir;
    logic        strobe_d;
    logic        commit_d;
    logic        perf;
    logic        power;
  } core_t;

endpackage
`default_nettype wire

// ==== vga_sync_bank.sv ====
// Two flip-flop synchroniser bank for pins entering the system clock domain
`timescale 1ns/1ns
`default_nettype none
module vga_sync_bank #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Asynchronous levels and their synchronised copies
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;

  sync_t state;
  sync_t next_state;

  // First stage feeds only the second stage
  always_comb begin
    next_state.first  = async_in;
    next_state.second = state.first;
  end

  // Register both stages
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.second;

endmodule // vga_sync_bank
`default_nettype wire
